// ==== sim/kdsd_decoder_asserts.sv ====
// Port-level checks on the segment decoder
`timescale 1ns/10ps
module kdsd_decoder_asserts
    import kdsd_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        reqValid,
    input wire logic        reqFetch,
    input wire logic [31:0] reqVaddr,
    input wire logic        debugModeBit,
    input wire logic        loadStoreOverrideBit,
    input wire logic        accessFault,
    input wire logic        probeDone,
    input wire logic        outValid,
    input wire kdsd_seg_e   outSegId,
    input wire logic [31:0] outPaddr,
    input wire logic        outToProbe,
    input wire logic        outToDreg,
    input wire logic        outDebugExc,
    input wire logic        outStall
);
    // ----------------------------------------
    // Request qualifiers
    // ----------------------------------------
    // Taken only when no probe reference is pending
    wire       take = reqValid && !outStall && !outToProbe && !(debugModeBit && accessFault);
    wire [2:0] hi   = reqVaddr[31:29];
    // Debug segment reference not sent back to the top segment
    wire       dsub = debugModeBit && reqVaddr[31:21] == 11'h7F9
                      && (reqFetch || !loadStoreOverrideBit);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_probe_take; take && dsub && !reqVaddr[20]; endsequence
    sequence s_done; outStall && probeDone; endsequence
    cached_xlate_a: assert property (take && hi == 3'h4 |=> outValid &&
        outSegId == KDSD_ID_CACHED && outPaddr == $past(reqVaddr) - 32'h8000_0000)
        else $error("cached segment decode wrong");
    uncached_xlate_a: assert property (take && hi == 3'h5 |=> outValid &&
        outSegId == KDSD_ID_UNCACHED && outPaddr == $past(reqVaddr) - 32'hA000_0000)
        else $error("uncached segment decode wrong");
    upper_seg_sel_a: assert property (take && hi == 3'h6 && !debugModeBit |=>
        outValid && outSegId == KDSD_ID_UPPER_A && outPaddr == $past(reqVaddr))
        else $error("upper segment decode wrong");
    top_seg_sel_a: assert property (take && hi == 3'h7 && !dsub |=> outValid &&
        outSegId == KDSD_ID_TOP && outPaddr == $past(reqVaddr) && !outToDreg && !outToProbe)
        else $error("top segment decode wrong");
    debug_exc_a: assert property (reqValid && !outStall && !outToProbe &&
        debugModeBit && accessFault |=> outDebugExc && !outValid)
        else $error("debug fault not raised");
    probe_route_a: assert property (s_probe_take |=> outToProbe && outStall &&
        outPaddr == {12'h000, $past(reqVaddr[19:0])}) else $error("probe route wrong");
    probe_done_a: assert property (s_done |=> !outStall && outValid && outToProbe
        ##1 !outToProbe) else $error("probe completion wrong");
    dreg_route_a: assert property (take && dsub && reqVaddr[20] |=> outValid &&
        outToDreg && outSegId == KDSD_ID_DREG && outPaddr == {12'h000, $past(reqVaddr[19:0])})
        else $error("debug register route wrong");
endmodule : kdsd_decoder_asserts
bind kdsd_decoder kdsd_decoder_asserts kdsd_decoder_asserts_i (
    .mclk(mclk), .rst_b(rst_b), .reqValid(reqValid), .reqFetch(reqFetch),
    .reqVaddr(reqVaddr), .debugModeBit(debugModeBit),
    .loadStoreOverrideBit(loadStoreOverrideBit), .accessFault(accessFault),
    .probeDone(probeDone), .outValid(outValid), .outSegId(outSegId), .outPaddr(outPaddr),
    .outToProbe(outToProbe), .outToDreg(outToDreg), .outDebugExc(outDebugExc),
    .outStall(outStall));

// ==== sim/kdsd_decoder_tb.sv ====
// Self-checking bench for the segment decoder
`timescale 1ns/10ps
module kdsd_decoder_tb;
    import kdsd_pkg::*;
    logic        mclk = 1'b0, rst_b = 1'b0, reqValid = 1'b0, reqFetch = 1'b0;
    logic        reqWrite = 1'b0, userModeBit = 1'b0, errorLevelBit = 1'b0;
    logic        exceptionLevelBit = 1'b0, debugModeBit = 1'b0, loadStoreOverrideBit = 1'b0;
    logic        probeEnableBit = 1'b0, cachedSegCacheable = 1'b0, accessFault = 1'b0;
    logic        dregImplemented = 1'b0, probeDone;
    logic [31:0] reqVaddr = 32'h0000_0000, vaddr, seed = 32'h0000_3098;
    logic [2:0]  lat = 3'h0;  // Probe answer delay
    logic        outValid, outMapped, outCached, outToProbe, outToDreg;
    logic        outDregWrEn, outDebugExc, outStall;
    logic [31:0] outPaddr;
    kdsd_seg_e   outSegId;
    int          badCount = 0, checksDone = 0, cycles = 0;
    logic [31:0] corner [12] = '{32'h8000_0000, 32'h9FFF_FFFF, 32'hA000_0000, 32'hBFFF_FFFF,
        32'hC000_0000, 32'hDFFF_FFFF, 32'hFF1F_FFFF, 32'hFF20_0000, 32'hFF2F_FFFF,
        32'hFF30_0000, 32'hFF3F_FFFF, 32'hFF40_0000};
    // Word size only toward debug registers
    kdsd_decoder #(.USE_TLB(1'b0)) kdsd_decoder_i (.mclk(mclk), .rst_b(rst_b),
        .reqValid(reqValid), .reqFetch(reqFetch), .reqWrite(reqWrite), .reqSize(2'h2),
        .reqVaddr(reqVaddr), .userModeBit(userModeBit), .errorLevelBit(errorLevelBit),
        .exceptionLevelBit(exceptionLevelBit), .debugModeBit(debugModeBit),
        .loadStoreOverrideBit(loadStoreOverrideBit), .probeEnableBit(probeEnableBit),
        .cachedSegCacheable(cachedSegCacheable), .accessFault(accessFault),
        .probeDone(probeDone), .dregImplemented(dregImplemented), .outValid(outValid),
        .outSegId(outSegId), .outPaddr(outPaddr), .outMapped(outMapped),
        .outCached(outCached), .outToProbe(outToProbe), .outToDreg(outToDreg),
        .outDregWrEn(outDregWrEn), .outDebugExc(outDebugExc), .outStall(outStall));
    kdsd_probe_model kdsd_probe_model_i (.mclk(mclk), .rst_b(rst_b), .outStall(outStall),
        .lat(lat), .probeDone(probeDone));
    logic        tlbMapped;  // Mapped flag of the translating variant
    // Translating variant on the same inputs; its probe timing matches the fixed one
    if (1'b1) begin : g_tlb
        kdsd_decoder #(.USE_TLB(1'b1)) kdsd_decoder_i (.mclk(mclk), .rst_b(rst_b),
            .reqValid(reqValid), .reqFetch(reqFetch), .reqWrite(reqWrite), .reqSize(2'h2),
            .reqVaddr(reqVaddr), .userModeBit(userModeBit), .errorLevelBit(errorLevelBit),
            .exceptionLevelBit(exceptionLevelBit), .debugModeBit(debugModeBit),
            .loadStoreOverrideBit(loadStoreOverrideBit), .probeEnableBit(probeEnableBit),
            .cachedSegCacheable(cachedSegCacheable), .accessFault(accessFault),
            .probeDone(probeDone), .dregImplemented(dregImplemented), .outValid(),
            .outSegId(), .outPaddr(), .outMapped(tlbMapped), .outCached(), .outToProbe(),
            .outToDreg(), .outDregWrEn(), .outDebugExc(), .outStall());
    end
    always #5 mclk = ~mclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    // Expected outputs for a kernel-space address in the fixed variant
    function automatic logic [40:0] expv(input logic [31:0] a, input logic f, o, d, w, c, im);
        kdsd_seg_e   s;
        logic [31:0] p;
        logic        ca, dsg;
        dsg = d && a[31:21] == 11'h7F9 && (f || !o);
        s   = kdsd_seg_e'(3'(a[31:29] - 3'h3));
        p   = a[30] ? a : a - (a[29] ? 32'hA000_0000 : 32'h8000_0000);
        ca  = a[30] | (!a[29] & c);
        if (dsg) begin
            s  = a[20] ? KDSD_ID_DREG : KDSD_ID_PROBE;
            p  = {12'h000, a[19:0]};
            ca = 1'b0;
        end
        return {1'b1, s, p, 1'b0, ca, dsg & !a[20], dsg & a[20], dsg & a[20] & w & im};
    endfunction : expv
    task automatic chk(input string what, input logic [40:0] e, input logic [40:0] g);
        checksDone++;
        if (g !== e) begin
            badCount++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    // One reference with random side bits, kernel privilege always held
    task automatic ref1(input logic [31:0] a, input logic f, o, d, flt);
        int          n;
        logic [40:0] e, g;
        logic        mt;
        seed = xs(seed);
        @(posedge mclk);
        #1;
        {reqWrite, dregImplemented, cachedSegCacheable, probeEnableBit} = seed[3:0];
        {userModeBit, errorLevelBit, lat} = seed[8:4];
        exceptionLevelBit = seed[9] | seed[8];
        {reqValid, reqVaddr, reqFetch, loadStoreOverrideBit, debugModeBit} = {1'b1, a, f, o, d};
        accessFault = flt;
        @(posedge mclk);
        #1;
        reqValid = 1'b0;
        accessFault = 1'b0;
        n = 0;
        while (outStall === 1'b1 && n < 40) begin
            @(posedge mclk);
            #1;
            n++;
        end
        e = flt ? 41'h1 : expv(a, f, o, d, reqWrite, cachedSegCacheable, dregImplemented);
        g = flt ? {39'h0, outValid, outDebugExc} : {outValid, outSegId, outPaddr, outMapped,
            outCached, outToProbe, outToDreg, outDregWrEn};
        chk("decode", e, g);
        // Translating variant marks only plain upper and top references as mapped
        mt = !flt && a[30] && !(d && a[31:21] == 11'h7F9 && (f || !o));
        chk("mapped tlb", {40'h0, mt}, {40'h0, tlbMapped});
    endtask : ref1
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    // Hang guard, well above the expected run length
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            print_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge mclk);
        #1 rst_b = 1'b1;
        foreach (corner[i]) begin
            for (int k = 0; k < 8; k++) begin
                ref1(corner[i], k[0], k[1], k[2], 1'b0);
            end
        end
        $display("test corners done");
        for (int i = 0; i < 200; i++) begin
            seed = xs(seed);
            vaddr = seed[31:30] == 2'h0 ? {11'h7F9, seed[20:0]} : {1'b1, seed[30:0]};
            ref1(vaddr, seed[21], seed[22], seed[23] | seed[24], 1'b0);
        end
        $display("test random done");
        for (int i = 0; i < 20; i++) begin
            seed = xs(seed);
            ref1({1'b1, seed[30:0]}, seed[0], seed[1], 1'b1, 1'b1);
        end
        $display("test debug fault done");
        print_verdict();
    end
endmodule : kdsd_decoder_tb

// ==== sim/kdsd_probe_model.sv ====
// Debug probe model answering held probe references
`timescale 1ns/10ps
module kdsd_probe_model (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       outStall,  // Reference held for probe
    input  wire logic [2:0] lat,       // Wait before answering
    output logic            probeDone  // One-cycle completion
);
    logic [2:0] cnt_q;   // Cycles waited
    logic       sent_q;  // Already answered
    // Answers even with probe enable clear, since software may race the clear
    always_ff @(posedge mclk) begin
        if (!rst_b || !outStall) begin
            cnt_q     <= 3'h0;
            sent_q    <= 1'b0;
            probeDone <= 1'b0;
        end else if (!sent_q && cnt_q == lat) begin
            probeDone <= 1'b1;
            sent_q    <= 1'b1;
        end else begin
            probeDone <= 1'b0;
            cnt_q     <= cnt_q + 3'h1;
        end
    end
endmodule : kdsd_probe_model

// ==== src/kdsd_cfg.svh ====
// Constants for the kernel and debug segment decoder
`ifndef KDSD_CFG_SVH
`define KDSD_CFG_SVH
// ----------------------------------------------------------------------
// Segment selection on address bits 31:29
// ----------------------------------------------------------------------
`define KDSD_SEG_CACHED     3'h4
`define KDSD_SEG_UNCACHED   3'h5
`define KDSD_SEG_UPPER_A    3'h6
`define KDSD_SEG_TOP        3'h7
// ----------------------------------------------------------------------
// Lower kernel segment bases subtracted on translation
// ----------------------------------------------------------------------
`define KDSD_CACHED_BASE    32'h8000_0000
`define KDSD_UNCACHED_BASE  32'hA000_0000
// ----------------------------------------------------------------------
// Debug segment decode, bits 31:20
// ----------------------------------------------------------------------
`define KDSD_PROBE_HI       12'hFF2
`define KDSD_DREG_HI        12'hFF3
`define KDSD_SUB_OFS_MSB    19
// ----------------------------------------------------------------------
// Translation buffer sizes
// ----------------------------------------------------------------------
`define KDSD_JOINT_PAIRS    16
`define KDSD_MICRO_ENTRIES  3
`endif

// ==== src/kdsd_classify.sv ====
// Combinational segment classifier
`timescale 1ns/10ps
`include "kdsd_cfg.svh"
module kdsd_classify
    import kdsd_pkg::*;
(
    kdsd_dec_if.cls dec
);
    // ------------------------------------------------------------------
    // Classification
    // ------------------------------------------------------------------
    logic [2:0]  top3;   // Address bits 31:29
    logic [11:0] top12;  // Address bits 31:20
    assign top3  = dec.vaddr[31:29];
    assign top12 = dec.vaddr[31:20];

    // Segment picked from top bits; debug segment only in debug mode
    always_comb begin
        dec.segId      = KDSD_ID_USER;
        dec.inDebugSeg = 1'b0;
        if (dec.kernelMode || dec.debugMode) begin
            case (top3)
                `KDSD_SEG_CACHED:   dec.segId = KDSD_ID_CACHED;
                `KDSD_SEG_UNCACHED: dec.segId = KDSD_ID_UNCACHED;
                `KDSD_SEG_UPPER_A:  dec.segId = KDSD_ID_UPPER_A;
                `KDSD_SEG_TOP:      dec.segId = KDSD_ID_TOP;
                default:            dec.segId = KDSD_ID_USER;
            endcase
            if (dec.debugMode && top12 == `KDSD_PROBE_HI) begin
                dec.segId      = KDSD_ID_PROBE;
                dec.inDebugSeg = 1'b1;
            end
            if (dec.debugMode && top12 == `KDSD_DREG_HI) begin
                dec.segId      = KDSD_ID_DREG;
                dec.inDebugSeg = 1'b1;
            end
        end
    end
endmodule : kdsd_classify

// ==== src/kdsd_dec_if.sv ====
// Carrier between the main decoder and the segment classifier
`timescale 1ns/10ps
interface kdsd_dec_if;
    import kdsd_pkg::*;
    logic [31:0] vaddr;       // Virtual address
    logic        kernelMode;  // Kernel privilege
    logic        debugMode;   // Debug mode active
    kdsd_seg_e   segId;       // Classified segment
    logic        inDebugSeg;  // Address falls in debug segment
    modport req (output vaddr, output kernelMode, output debugMode,
                 input segId, input inDebugSeg);
    modport cls (input vaddr, input kernelMode, input debugMode,
                 output segId, output inDebugSeg);
endinterface : kdsd_dec_if

// ==== src/kdsd_decoder.sv ====
// Kernel and debug segment decoder top level
// Notes on behaviour
// - Bits 110 in kernel, non-debug select upper segment A.
// - Bits 111 in kernel select top segment.
// - Fixed variant passes upper segments through unchanged.
// - TLB variant sends upper segments to translation.
// - Debug mode decodes as kernel; debug segment uncached.
// - Probe range maps to probe offsets.
// - Register range maps to debug register offsets.
// - Debug-mode faults raise debug exception instead.
// - Lower unmapped kernel segments usable in debug.
// - Register range: override loads/stores go top segment.
// - Unimplemented register reads unspecified, writes dropped.
// - Probe range: override to top; else probe.
// - Probe disabled: still forward, stall until done.
// - TLB variant: 16-pair joint, two 3-entry micro.
// - Bits 100: subtract cached base, configurable cacheability.
// - Bits 101: subtract uncached base, caches off.
`timescale 1ns/10ps
`include "kdsd_cfg.svh"
module kdsd_decoder
    import kdsd_pkg::*;
#(
    parameter bit USE_TLB       = 1'b0,               // Variant select
    parameter int JOINT_PAIRS   = `KDSD_JOINT_PAIRS,  // Joint buffer pairs
    parameter int MICRO_ENTRIES = `KDSD_MICRO_ENTRIES // Each micro buffer
)(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        reqValid,          // Reference presented
    input  wire logic        reqFetch,          // 1 fetch, 0 load/store
    input  wire logic        reqWrite,          // Store
    input  wire logic [1:0]  reqSize,           // 2 means word
    input  wire logic [31:0] reqVaddr,          // Virtual address
    input  wire logic        userModeBit,
    input  wire logic        errorLevelBit,
    input  wire logic        exceptionLevelBit,
    input  wire logic        debugModeBit,
    input  wire logic        loadStoreOverrideBit,
    input  wire logic        probeEnableBit,
    input  wire logic        cachedSegCacheable, // Configured cacheability
    input  wire logic        accessFault,       // Kernel-mode fault seen
    input  wire logic        probeDone,         // Probe finished reference
    input  wire logic        dregImplemented,   // Target register exists
    output logic             outValid,
    output kdsd_seg_e        outSegId,
    output logic [31:0]      outPaddr,          // Physical address or offset
    output logic             outMapped,         // Needs TLB translation
    output logic             outCached,
    output logic             outToProbe,
    output logic             outToDreg,
    output logic             outDregWrEn,       // Write allowed to register
    output logic             outDebugExc,       // Debug mode exception
    output logic             outStall           // Reference held for probe
);
    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // Only the documented buffer sizes are served; refuse others at elaboration
    if (JOINT_PAIRS != `KDSD_JOINT_PAIRS ||
        MICRO_ENTRIES != `KDSD_MICRO_ENTRIES) begin : g_size_chk
        $error("Translation buffer sizes are fixed");
    end

    // ------------------------------------------------------------------
    // Segment classification
    // ------------------------------------------------------------------
    kdsd_dec_if dec ();
    logic kernelMode; // Privileged, debug clear
    assign kernelMode = (!userModeBit || errorLevelBit || exceptionLevelBit)
                        && !debugModeBit;
    assign dec.vaddr      = reqVaddr;
    assign dec.kernelMode = kernelMode;
    assign dec.debugMode  = debugModeBit;

    kdsd_classify kdsd_classify_i (
        .dec (dec)
    );

    // ------------------------------------------------------------------
    // Next-value logic
    // ------------------------------------------------------------------
    kdsd_state_e state_q, state_d;   // Probe wait tracking
    logic        valid_d, mapped_d, cached_d, probe_d, dreg_d, wr_d, exc_d;
    logic        valid_q, mapped_q, cached_q, probe_q, dreg_q, wr_q, exc_q;
    logic        stall_d, stall_q;
    kdsd_seg_e   seg_d, seg_q;
    logic [31:0] paddr_d, paddr_q;
    logic [31:0] subOfs;             // Offset inside a debug subsegment
    logic        override;           // Load/store redirected to top segment

    assign subOfs   = {12'h000, reqVaddr[`KDSD_SUB_OFS_MSB:0]};
    assign override = !reqFetch && loadStoreOverrideBit;

    // Decode one reference; probe wait holds until probe finishes
    always_comb begin
        state_d  = state_q;
        valid_d  = 1'b0;
        seg_d    = seg_q;
        paddr_d  = paddr_q;
        mapped_d = 1'b0;
        cached_d = 1'b0;
        probe_d  = 1'b0;
        dreg_d   = 1'b0;
        wr_d     = 1'b0;
        exc_d    = 1'b0;
        stall_d  = 1'b0;
        case (state_q)
            KDSD_IDLE: begin
                if (reqValid && debugModeBit && accessFault) begin
                    // Fault in debug re-enters debug, skips MMU handler
                    // No decode result reported, the old segment would be stale
                    exc_d   = 1'b1;
                end else if (reqValid) begin
                    valid_d = 1'b1;
                    seg_d   = dec.segId;
                    paddr_d = reqVaddr;
                    case (dec.segId)
                        KDSD_ID_CACHED: begin
                            paddr_d  = reqVaddr - `KDSD_CACHED_BASE;
                            cached_d = cachedSegCacheable;
                        end
                        KDSD_ID_UNCACHED: begin
                            paddr_d  = reqVaddr - `KDSD_UNCACHED_BASE;
                        end
                        KDSD_ID_UPPER_A, KDSD_ID_TOP: begin
                            mapped_d = USE_TLB;
                            cached_d = 1'b1;
                        end
                        KDSD_ID_PROBE: begin
                            if (override) begin
                                seg_d    = KDSD_ID_TOP;
                                mapped_d = USE_TLB;
                                cached_d = 1'b1;        // Ordinary top segment
                            end else begin
                                paddr_d = subOfs;
                                probe_d = 1'b1;
                                stall_d = 1'b1;
                                valid_d = 1'b0;
                                state_d = KDSD_PROBE;
                            end
                        end
                        KDSD_ID_DREG: begin
                            if (override) begin
                                seg_d    = KDSD_ID_TOP;
                                mapped_d = USE_TLB;
                                cached_d = 1'b1;        // Ordinary top segment
                            end else begin
                                paddr_d = subOfs;
                                dreg_d  = 1'b1;
                                // Missing registers drop writes
                                wr_d    = reqWrite && dregImplemented;
                            end
                        end
                        default: begin
                            mapped_d = 1'b1;
                            cached_d = 1'b1;
                        end
                    endcase
                end
            end
            KDSD_PROBE: begin
                // Held regardless of enable; probe must still answer
                probe_d = 1'b1;
                stall_d = !probeDone;
                if (probeDone) begin
                    valid_d = 1'b1;
                    state_d = KDSD_IDLE;
                end
            end
            default: state_d = KDSD_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_q  <= KDSD_IDLE;
            valid_q  <= 1'b0;
            seg_q    <= KDSD_ID_USER;
            paddr_q  <= 32'h0000_0000;
            mapped_q <= 1'b0;
            cached_q <= 1'b0;
            probe_q  <= 1'b0;
            dreg_q   <= 1'b0;
            wr_q     <= 1'b0;
            exc_q    <= 1'b0;
            stall_q  <= 1'b0;
        end else begin
            state_q  <= state_d;
            valid_q  <= valid_d;
            seg_q    <= seg_d;
            paddr_q  <= paddr_d;
            mapped_q <= mapped_d;
            cached_q <= cached_d;
            probe_q  <= probe_d;
            dreg_q   <= dreg_d;
            wr_q     <= wr_d;
            exc_q    <= exc_d;
            stall_q  <= stall_d;
        end
    end

    // Outputs straight from flip-flops (segment, mapped, cached)
    assign outValid    = valid_q;
    assign outSegId    = seg_q;
    assign outPaddr    = paddr_q;
    assign outMapped   = mapped_q;
    assign outCached   = cached_q;
    assign outToProbe  = probe_q;
    assign outToDreg   = dreg_q;
    assign outDregWrEn = wr_q;
    assign outDebugExc = exc_q;
    assign outStall    = stall_q;
endmodule : kdsd_decoder

// ==== src/kdsd_pkg.sv ====
// Types shared by the kernel and debug segment decoder
package kdsd_pkg;
    // Segment identifier
    typedef enum logic [2:0] {
        KDSD_ID_USER     = 3'h0,
        KDSD_ID_CACHED   = 3'h1,
        KDSD_ID_UNCACHED = 3'h2,
        KDSD_ID_UPPER_A  = 3'h3,
        KDSD_ID_TOP      = 3'h4,
        KDSD_ID_PROBE    = 3'h5,
        KDSD_ID_DREG     = 3'h6
    } kdsd_seg_e;
    // Reference tracking state
    typedef enum logic [1:0] {
        KDSD_IDLE  = 2'h0,
        KDSD_PROBE = 2'h1
    } kdsd_state_e;
endpackage : kdsd_pkg
